/* File: core/ddi_source.sv */
// Data source end: word FIFO, strobe and clock generation, pairing reset.
`timescale 1ns/1ps
`default_nettype none
module ddi_fifo #(
  parameter int unsigned WIDTH = 20,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset.
  input  wire logic             clock_i,
  input  wire logic             rst_b_i,
  // Filling side.
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Draining side.
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Index wrap relies on a power-of-two depth.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("ddi_fifo: depth must be a power of two of at least 2");
  end

  logic [DEPTH-1:0][WIDTH-1:0] mem_q;  // Storage flops.
  logic [AW-1:0]               wp_q;   // Write index.
  logic [AW-1:0]               rp_q;   // Read index.
  logic [AW:0]                 cnt_q;  // Words held.

  wire push = in_valid_i && in_ready_o;
  wire pop  = out_valid_o && out_ready_i;

  assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rp_q];

  // Indices and count move on push and pop.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        mem_q[wp_q] <= in_data_i;
        wp_q        <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

module ddi_source
  import ddi_pkg::*;
#(
  parameter int unsigned W     = DATA_W,
  parameter int unsigned HALF  = HALF_CYC,
  parameter int unsigned DEPTH = FIFO_DEPTH,
  parameter int unsigned PRPER = PAIR_RST_PER
) (
  // Clock and reset.
  input  wire logic          clock_i,
  input  wire logic          rst_b_i,
  // User word stream: each entry is one A/B pair.
  input  wire logic          pair_valid_i,
  output logic               pair_ready_o,
  input  wire logic [W-1:0]  word_a_i,
  input  wire logic [W-1:0]  word_b_i,
  // Configuration.
  input  wire logic          mode_i,
  input  wire logic          pair_reset_req_i,
  // Status.
  output logic               underrun_o,
  // Link pins.
  ddi_link_if.src            link
);

  // Strobe rate must leave the converter at or below its maximum update rate.
  if (HALF < 2 || PRPER < 1 ||
      1000 / (CLK_PERIOD_NS * 2 * HALF) > MAX_RATE_MSPS) begin : g_bad_cfg
    $error("ddi_source: strobe half period or pairing reset length unsupported");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Strobe divider; clock and write share edges, so the clock never lags.

  logic [$clog2(HALF+1)-1:0] ph_q;   // Cycle within a half period.
  logic                      lvl_q;  // Strobe and clock level.
  wire tick    = (ph_q == ($clog2(HALF+1))'(HALF - 1));
  wire fall_en = tick && lvl_q;      // Data changes here, far from the rise.

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      ph_q  <= '0;
      lvl_q <= 1'b0;
    end else begin
      ph_q  <= tick ? '0 : ph_q + 1'b1;
      lvl_q <= tick ? ~lvl_q : lvl_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Word buffer.

  logic            f_valid;
  logic            f_ready;
  logic [2*W-1:0]  f_data;

  ddi_fifo #(.WIDTH(2 * W), .DEPTH(DEPTH)) u_fifo (
    .clock_i     (clock_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (pair_valid_i),
    .in_ready_o  (pair_ready_o),
    .in_data_i   ({word_b_i, word_a_i}),
    .out_valid_o (f_valid),
    .out_ready_i (f_ready),
    .out_data_o  (f_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Pairing reset and word sequencing.

  logic                          mode_q;   // Mode driven on the pin.
  logic                          init_q;   // Low until the first pairing reset.
  logic [$clog2(PRPER+1)-1:0]    pr_q;     // Strobe periods of pairing reset left.
  logic                          ab_q;     // Shared mode: next word is B.
  logic [W-1:0]                  bus_a_q;
  logic [W-1:0]                  bus_b_q;
  logic [W-1:0]                  pend_b_q; // B word waiting for its slot.
  logic [W-1:0]                  pend_a_q; // Last A word, resent while starved.
  logic                          und_q;

  wire start_pr = !init_q || pair_reset_req_i || (mode_i != mode_q);
  wire in_pr    = (pr_q != '0);
  wire last_pr  = (pr_q == ($clog2(PRPER+1))'(1));
  // Shared mode pops on A slots only, giving twice the word rate on bus A.
  // No pop while a pairing reset starts, or the popped word would be lost.
  wire want     = fall_en && !start_pr && (!in_pr || last_pr) &&
                  !(mode_q == MODE_SHARED && ab_q);
  assign f_ready = want;

  // Pairing reset ends on a strobe fall, when the next A word is placed.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      mode_q   <= MODE_DUAL;
      init_q   <= 1'b0;
      pr_q     <= '0;
      ab_q     <= 1'b0;
      bus_a_q  <= '0;
      bus_b_q  <= '0;
      pend_b_q <= '0;
      pend_a_q <= '0;
      und_q    <= 1'b0;
    end else if (start_pr) begin
      mode_q <= mode_i;
      init_q <= 1'b1;
      pr_q   <= ($clog2(PRPER+1))'(PRPER);
      ab_q   <= 1'b0;
    end else if (fall_en) begin
      if (in_pr) begin
        pr_q <= pr_q - 1'b1;
      end
      // The fall that ends the pairing reset already carries the first A word.
      if (!in_pr || last_pr) begin
        if (mode_q == MODE_SHARED && ab_q) begin
          bus_a_q <= pend_b_q;
          ab_q    <= 1'b0;
        end else begin
          und_q <= !f_valid;
          if (f_valid) begin
            bus_a_q  <= f_data[W-1:0];
            bus_b_q  <= f_data[2*W-1:W];
            pend_a_q <= f_data[W-1:0];
            pend_b_q <= f_data[2*W-1:W];
          end else begin
            // Starved: resend the last pair in order, so B is never paired with B.
            bus_a_q <= pend_a_q;
          end
          ab_q <= (mode_q == MODE_SHARED);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pins.

  assign link.mode                = mode_q;
  assign link.bus_a               = bus_a_q;
  assign link.bus_b               = bus_b_q;
  assign link.chan_a_write_strobe = lvl_q;
  assign link.chan_b_write_strobe = lvl_q;
  assign link.chan_a_conv_clock   = lvl_q;
  assign link.chan_b_conv_clock   = lvl_q;
  assign link.pairing_reset       = in_pr;
  assign underrun_o               = und_q;

endmodule
`default_nettype wire

/* File: core/ddi_pkg.sv */
// Shared constants for the dual converter input link and its two ends.
package ddi_pkg;

  // Data word layout.
  localparam int unsigned DATA_W        = 10;  // Offset binary word, bit 9 is the MSB.
  localparam int unsigned DATA_MSB      = 9;   // Position of the most significant bit.

  // Converter latency, counted in converter clock rising edges.
  localparam int unsigned LAT_CLK       = 4;

  // System clock and link timing.
  localparam int unsigned CLK_PERIOD_NS = 10;  // 100 MHz system clock.
  localparam int unsigned CLK_LAG_NS    = 2;   // Least lag of clock behind write.
  localparam int unsigned CLK_LAG_CYC   =
    ((CLK_LAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
    (CLK_LAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MAX_RATE_MSPS = 200; // Highest converter update rate.

  // Source side defaults.
  localparam int unsigned HALF_CYC      = 2;   // System cycles per strobe half period.
  localparam int unsigned FIFO_DEPTH    = 8;   // A/B pairs buffered ahead of the link.
  localparam int unsigned PAIR_RST_PER  = 2;   // Strobe periods the pairing reset lasts.

  // Mode pin encoding.
  localparam logic        MODE_SHARED   = 1'b0; // Interleaved words on bus A.
  localparam logic        MODE_DUAL     = 1'b1; // Two independent buses.

  // Reset values.
  localparam logic        SEL_RST       = 1'b1; // Channel select starts on channel A.

endpackage

/* File: core/ddi_link_if.sv */
// Pin-level link between the data source and the converter input front end.
`timescale 1ns/1ps
`default_nettype none
interface ddi_link_if;
  import ddi_pkg::*;

  logic              mode;                // Static mode pin, low shared, high dual.
  logic [DATA_W-1:0] bus_a;               // Channel A bus, also the shared bus.
  logic [DATA_W-1:0] bus_b;               // Channel B bus, unused when shared.
  logic              chan_a_write_strobe; // Also the shared write strobe.
  logic              chan_b_write_strobe; // Channel B write strobe.
  logic              chan_a_conv_clock;   // Also the shared input clock.
  logic              chan_b_conv_clock;   // Channel B converter clock.
  logic              pairing_reset;       // Fixes the divided clock phase.

  // The converter end only listens.
  modport dev (
    input mode, bus_a, bus_b, chan_a_write_strobe, chan_b_write_strobe,
          chan_a_conv_clock, chan_b_conv_clock, pairing_reset
  );

  // The source end drives every pin.
  modport src (
    output mode, bus_a, bus_b, chan_a_write_strobe, chan_b_write_strobe,
           chan_a_conv_clock, chan_b_conv_clock, pairing_reset
  );
endinterface
`default_nettype wire

/* File: core/ddi_device.sv */
// Converter input front end: input latches, channel steering and converter latches.
//
// What this block does
// - Words are 10-bit offset binary, bit 9 MSB.
// - Static mode pin picks shared or dual bus.
// - Dual mode channels use own bus, strobe, clock.
// - Write rise loads input latch; clock drives next.
// - Written word reaches output four clocks later.
// - Clock rise leads write, or lags 2 ns.
// - Shared mode uses bus A only, B ignored.
// - Shared mode: one strobe, one clock, derived clock.
// - Select high loads A, low loads B.
// - Source sends words at twice core rate.
// - Capture on strobe rise, pass on fall.
// - Shared clock divided by two updates converters.
// - Pairing reset high holds divided clock low.
// - Pairing reset fixes A/B pairing phase.
// - Symmetric duty cycle preferred for strobes, clocks.
// - Converter updates no faster than 200 MSPS.
`timescale 1ns/1ps
`default_nettype none
module ddi_device
  import ddi_pkg::*;
#(
  parameter int unsigned W   = DATA_W,
  parameter int unsigned LAT = LAT_CLK
) (
  // Clock and reset.
  input  wire logic          clock_i,
  input  wire logic          rst_b_i,
  // Link pins.
  ddi_link_if.dev            link,
  // Converter core words and observed internal timing.
  output logic [W-1:0]       dac_a_o,
  output logic [W-1:0]       dac_b_o,
  output logic               divided_conv_clock_o,
  output logic               channel_select_o,
  output logic               shared_mode_o
);

  // Refuse widths other than the link's and pipelines too short to shift.
  if (W != DATA_W || LAT < 2) begin : g_bad_cfg
    $error("ddi_device: unsupported width or latency");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  // All pins come from outside this clock; two flops before any use.
  localparam int unsigned PIN_W = 2 * W + 6;
  logic [PIN_W-1:0] pin_raw;    // Raw pin vector.
  logic [PIN_W-1:0] pin_m_q;    // First synchroniser stage, read only by the second.
  logic [PIN_W-1:0] pin_s_q;    // Second stage, safe to use.
  logic [3:0]       edge_q;     // Previous strobes and clocks, for edge detection.

  assign pin_raw = {link.mode, link.pairing_reset, link.chan_b_conv_clock,
                    link.chan_a_conv_clock, link.chan_b_write_strobe,
                    link.chan_a_write_strobe, link.bus_b, link.bus_a};

  // Synchroniser stages and edge history; data and strobes share the same delay.
  // Edge history resets low, the idle level of every strobe and clock, so no false
  // edge follows reset.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      pin_m_q <= '0;
      pin_s_q <= '0;
      edge_q  <= '0;
    end else begin
      pin_m_q <= pin_raw;
      pin_s_q <= pin_m_q;
      edge_q  <= pin_s_q[2*W +: 4];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decoding of the synchronised pins.

  wire [W-1:0] bus_a_s   = pin_s_q[W-1:0];     // Bit 9 is the MSB of each word.
  wire [W-1:0] bus_b_s   = pin_s_q[2*W-1:W];
  wire [3:0]   now_s     = pin_s_q[2*W +: 4];  // {clk_b, clk_a, wr_b, wr_a}.
  wire         prst_s    = pin_s_q[2*W+4];
  wire         shared    = (pin_s_q[2*W+5] == MODE_SHARED);
  wire [3:0]   rise      = now_s & ~edge_q;
  wire [3:0]   fall      = ~now_s & edge_q;
  wire         wr_a_rise = rise[0];            // Also the shared strobe rise.
  wire         wr_a_fall = fall[0];
  wire         wr_b_rise = rise[1];
  wire         clk_a_rise = rise[2];           // Also the shared clock rise.
  wire         clk_b_rise = rise[3];

  ////////////////////////////////////////////////////////////////////////////////
  // Input latches and interleave steering.

  logic [W-1:0] in_a_q;    // Channel A input latch.
  logic [W-1:0] in_b_q;    // Channel B input latch.
  logic [W-1:0] hold_a_q;  // Shared mode: A word handed over on strobe fall.
  logic [W-1:0] hold_b_q;  // Shared mode: B word handed over on strobe fall.
  logic         sel_q;     // Channel select, high steers the shared bus to A.

  // Shared mode takes bus A only; the select decides which latch loads.
  // In shared mode pairing reset freezes latch A directly and latch B through the select parked on A,
  // so no word left from before it can be paired with a word sent after it.
  wire          load_a = shared ? (wr_a_rise && sel_q && !prst_s) : wr_a_rise;
  wire          load_b = shared ? (wr_a_rise && !sel_q) : wr_b_rise;
  wire [W-1:0]  src_b  = shared ? bus_a_s : bus_b_s;

  // A latch not loaded keeps its value, which is the recirculation path.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      in_a_q <= '0;
      in_b_q <= '0;
    end else begin
      if (load_a) begin
        in_a_q <= bus_a_s;
      end
      if (load_b) begin
        in_b_q <= src_b;
      end
    end
  end

  // Select alternates per shared strobe rise; pairing reset parks it on A.
  // Mode is treated as static, so a change must be followed by a pairing reset.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      sel_q <= SEL_RST;
    end else if (prst_s) begin
      sel_q <= SEL_RST;
    end else if (shared && wr_a_rise) begin
      sel_q <= ~sel_q;
    end
  end

  // Both captured words pass on together at the next strobe fall.
  // The hold stage costs half a strobe period but keeps each A and B word together.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      hold_a_q <= '0;
      hold_b_q <= '0;
    end else if (shared && wr_a_fall) begin
      hold_a_q <= in_a_q;
      hold_b_q <= in_b_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Divided converter clock.

  logic div_q;  // Shared clock divided by two.

  // Held low under pairing reset so its first rise after release is known.
  // Dual mode keeps it low too, since each channel then runs on its own clock.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      div_q <= 1'b0;
    end else if (prst_s || !shared) begin
      div_q <= 1'b0;
    end else if (clk_a_rise) begin
      div_q <= ~div_q;
    end
  end

  // One strobe and one clock update both cores through the divided clock.
  wire upd_shared = shared && clk_a_rise && !div_q && !prst_s;
  wire upd_a      = shared ? upd_shared : clk_a_rise;
  wire upd_b      = shared ? upd_shared : clk_b_rise;
  wire [W-1:0] feed_a = shared ? hold_a_q : in_a_q;
  wire [W-1:0] feed_b = shared ? hold_b_q : in_b_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Converter latch pipelines.

  // The fixed depth makes a written word appear on the fourth update edge, and the
  // same depth serves both modes, so latency does not change with the mode.
  logic [LAT-1:0][W-1:0] pipe_a_q;
  logic [LAT-1:0][W-1:0] pipe_b_q;

  // With no update edge the pipelines hold; a starved source keeps clocking and resends its last
  // pair, so that pair stays standing on the converter.
  // Channel A pipeline, advanced only by its own update edge.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      pipe_a_q <= '0;
    end else if (upd_a) begin
      pipe_a_q <= {pipe_a_q[LAT-2:0], feed_a};
    end
  end

  // Channel B pipeline, independent of channel A in dual mode.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      pipe_b_q <= '0;
    end else if (upd_b) begin
      pipe_b_q <= {pipe_b_q[LAT-2:0], feed_b};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flops.

  assign dac_a_o              = pipe_a_q[LAT-1];
  assign dac_b_o              = pipe_b_q[LAT-1];
  assign divided_conv_clock_o = div_q;
  assign channel_select_o     = sel_q;
  assign shared_mode_o        = pin_s_q[2*W+5] == MODE_SHARED;

endmodule
`default_nettype wire

/* File: dv/ddi_monitor.sv */
// Checker for the link pins and the device's divided clock and select.
`timescale 1ns/1ps
`default_nettype none
module ddi_monitor
  import ddi_pkg::*;
(
  // Clock and reset.
  input  wire logic              clock_i,
  input  wire logic              rst_b_i,
  // Link pins.
  input  wire logic              mode,
  input  wire logic [DATA_W-1:0] bus_a,
  input  wire logic [DATA_W-1:0] bus_b,
  input  wire logic              chan_a_write_strobe,
  input  wire logic              chan_b_write_strobe,
  input  wire logic              chan_a_conv_clock,
  input  wire logic              chan_b_conv_clock,
  input  wire logic              pairing_reset,
  // Device status.
  input  wire logic              divided_conv_clock_o,
  input  wire logic              channel_select_o,
  input  wire logic              shared_mode_o
);
  // One domain, so clock and reset are given once for every property.
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  //////////////////////////////////////////////////////////////////////////////
  // Four cycles of pairing reset cover the two sync flops and the output flop.
  property p_div_held;
    pairing_reset [*4] |-> !divided_conv_clock_o;
  endproperty
  a_div_held: assert property (p_div_held) else $error("divided clock high in pairing");
  property p_sel_held;
    pairing_reset [*4] |-> channel_select_o;
  endproperty
  a_sel_held: assert property (p_sel_held) else $error("select low in pairing");
  // Zero lag between clock and write keeps the order rule trivially.
  property p_lag_a;
    chan_a_write_strobe == chan_a_conv_clock;
  endproperty
  a_lag_a: assert property (p_lag_a) else $error("channel A clock and write apart");
  property p_lag_b;
    chan_b_write_strobe == chan_b_conv_clock;
  endproperty
  a_lag_b: assert property (p_lag_b) else $error("channel B clock and write apart");
  // The strobe is high for exactly half its four-cycle period.
  property p_duty;
    $rose(chan_a_write_strobe) |-> chan_a_write_strobe [*2] ##1 !chan_a_write_strobe;
  endproperty
  a_duty: assert property (p_duty) else $error("strobe high time wrong");
  // Divided clock rises no more often than every second strobe period.
  property p_div_rate;
    $rose(divided_conv_clock_o) |=> (!$rose(divided_conv_clock_o)) [*7];
  endproperty
  a_div_rate: assert property (p_div_rate) else $error("divided clock too fast");
  property p_mode;
    $stable(mode) [*4] |-> shared_mode_o == (mode == MODE_SHARED);
  endproperty
  a_mode: assert property (p_mode) else $error("mode flag does not follow pin");
  // Words change only as the strobe falls, giving half a period of set-up.
  property p_bus_a;
    $changed(bus_a) |-> $fell(chan_a_write_strobe);
  endproperty
  a_bus_a: assert property (p_bus_a) else $error("bus A moved off strobe fall");
  property p_bus_b;
    $changed(bus_b) |-> $fell(chan_b_write_strobe);
  endproperty
  a_bus_b: assert property (p_bus_b) else $error("bus B moved off strobe fall");
  property p_pr_end;
    $fell(pairing_reset) |-> $fell(chan_a_write_strobe);
  endproperty
  a_pr_end: assert property (p_pr_end) else $error("pairing reset ends off a word");
endmodule
`default_nettype wire

/* File: dv/dual_dac_input_interface_test.sv */
// Self-checking bench: source and converter front end joined back to back.
`timescale 1ns/1ps
`default_nettype none
module dual_dac_input_interface_test;
  import ddi_pkg::*;

  logic                clock_i, rst_b_i;        // Clock and active-low reset.
  logic                pair_valid, pair_ready;  // Source user handshake.
  logic [DATA_W-1:0]   word_a, word_b;          // Pair offered to the source.
  logic                mode_sel, pr_req, underrun;
  logic [DATA_W-1:0]   dac_a, dac_b;            // Converter words seen.
  logic                div_clk, sel, shared;
  logic [2*DATA_W-1:0] exp_q[$];                // Expected {B,A} pairs in order.
  logic [2*DATA_W-1:0] last_seen, prev_pair;
  logic                watching, saw_full, saw_under;
  int                  n_mismatch, checks_done, seed;

  //////////////////////////////////////////////////////////////////////////////
  ddi_link_if link ();
  ddi_source #(.HALF(2), .PRPER(2)) u_ddi_source (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .pair_valid_i(pair_valid),
    .pair_ready_o(pair_ready), .word_a_i(word_a), .word_b_i(word_b),
    .mode_i(mode_sel), .pair_reset_req_i(pr_req), .underrun_o(underrun), .link(link));
  ddi_device u_ddi_device (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .link(link), .dac_a_o(dac_a), .dac_b_o(dac_b),
    .divided_conv_clock_o(div_clk), .channel_select_o(sel), .shared_mode_o(shared));
  ddi_monitor u_ddi_monitor (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .mode(link.mode), .bus_a(link.bus_a),
    .bus_b(link.bus_b), .chan_a_write_strobe(link.chan_a_write_strobe),
    .chan_b_write_strobe(link.chan_b_write_strobe),
    .chan_a_conv_clock(link.chan_a_conv_clock), .chan_b_conv_clock(link.chan_b_conv_clock),
    .pairing_reset(link.pairing_reset), .divided_conv_clock_o(div_clk),
    .channel_select_o(sel), .shared_mode_o(shared));

  // 100 MHz clock.
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Counts a comparison and reports a mismatch at once.
  task automatic check(input logic [2*DATA_W-1:0] seen, input logic [2*DATA_W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Single place where the run ends.
  task automatic end_of_test();
    $display("Counts: %0d checks, %0d mismatches", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Full reset with a new mode; the mode pin is only trusted after a reset.
  task automatic restart(input logic m);
    watching = 1'b0;
    rst_b_i <= 1'b0;
    mode_sel <= m;
    repeat (4) @(posedge clock_i);
    rst_b_i <= 1'b1;
    exp_q.delete();
    last_seen = '0;
    prev_pair = '0;
    @(posedge clock_i);
    watching = 1'b1;
  endtask

  // Offers one random pair and holds it until the source takes it.
  task automatic push_pair();
    logic [2*DATA_W-1:0] p;
    p = 20'($random(seed));
    // The watcher sees changes only, so neighbouring pairs must differ.
    if (p == prev_pair) begin
      p = ~p;
    end
    prev_pair = p;
    pair_valid <= 1'b1;
    word_a <= p[DATA_W-1:0];
    word_b <= p[2*DATA_W-1:DATA_W];
    @(posedge clock_i);
    for (int i = 0; i < 500 && !pair_ready; i++) begin
      saw_full = 1'b1;
      @(posedge clock_i);
    end
    exp_q.push_back(p);
  endtask

  task automatic idle();
    pair_valid <= 1'b0;
    @(posedge clock_i);
  endtask

  // Waits for every noted pair to reach the converter words.
  task automatic drain(input string name);
    for (int i = 0; i < 3000 && exp_q.size() != 0; i++) begin
      @(posedge clock_i);
    end
    check(20'(exp_q.size()), 20'h00000);
    $display("Test %s done", name);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Watcher: every new word pair is matched against the oldest note.
  always @(posedge clock_i) begin
    if (underrun === 1'b1) begin
      saw_under = 1'b1;
    end
    if (watching && {dac_b, dac_a} !== last_seen) begin
      last_seen = {dac_b, dac_a};
      if (exp_q.size() == 0) begin
        check(last_seen, ~last_seen);
      end else begin
        check(last_seen, exp_q.pop_front());
      end
    end
  end

  // Main sequence: both modes, burst to full, gaps, then a re-pairing.
  initial begin
    seed = 85;
    rst_b_i = 1'b0;
    pair_valid = 1'b0;
    word_a = '0;
    word_b = '0;
    mode_sel = MODE_DUAL;
    pr_req = 1'b0;
    watching = 1'b0;
    saw_full = 1'b0;
    saw_under = 1'b0;
    n_mismatch = 0;
    checks_done = 0;
    @(posedge clock_i);
    for (int m = 0; m < 2; m++) begin
      restart(m[0] ? MODE_SHARED : MODE_DUAL);
      saw_full = 1'b0;
      repeat (20) push_pair();
      idle();
      drain("burst");
      check(20'(saw_full), 20'h00001);
      saw_under = 1'b0;
      // Slow source: the link must hold its words while starved.
      repeat (3) begin
        push_pair();
        idle();
        repeat (40) @(posedge clock_i);
      end
      drain("gaps");
      check(20'(saw_under), 20'h00001);
      pr_req <= 1'b1;
      @(posedge clock_i);
      pr_req <= 1'b0;
      repeat (30) @(posedge clock_i);
      repeat (6) push_pair();
      idle();
      drain("repair");
    end
    end_of_test();
  end

  // Watchdog, far beyond the thousand or so cycles the tests need.
  initial begin
    repeat (30000) @(posedge clock_i);
    n_mismatch++;
    end_of_test();
  end
endmodule
`default_nettype wire
